// *** rxq_pkg.sv ***
package rxq_pkg;
   // fifo
   localparam int FIFO_DEPTH = 64;
   localparam int CNT_W = 7;
   localparam logic [CNT_W-1:0] FIFO_FULL = 7'h40;
   localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
   localparam logic [3:0] STB_CNT_MAX = 4'hF;
   // pin function codes
   localparam logic [5:0] PIN_FIFO_THR = 6'h00;
   localparam logic [5:0] PIN_FIFO_EOP = 6'h01;
   localparam logic [5:0] PIN_SYNC_PKT = 6'h06;
   localparam logic [5:0] PIN_CS = 6'h0E;
   // sync qualifier modes, bit 2 adds carrier sense
   localparam logic [1:0] SYNC_NONE = 2'h0;
   localparam logic [1:0] SYNC_15_16 = 2'h1;
   localparam logic [1:0] SYNC_16_16 = 2'h2;
   localparam logic [1:0] SYNC_30_32 = 2'h3;
   localparam int SYNC_CS_BIT = 2;
   localparam logic [5:0] ERR_NONE = 6'h00;
   localparam logic [5:0] ERR_16 = 6'h01;
   localparam logic [5:0] ERR_32 = 6'h02;
   // modulation formats
   localparam logic [2:0] MOD_OOK = 3'h3;
   localparam logic [2:0] MOD_4FSK = 3'h4;
   // discriminator levels and four-level symbols
   localparam logic [1:0] LVL_NEG_FULL = 2'h0;
   localparam logic [1:0] LVL_NEG_THIRD = 2'h1;
   localparam logic [1:0] LVL_POS_THIRD = 2'h2;
   localparam logic [1:0] SYM_NEG_FULL = 2'h1;
   localparam logic [1:0] SYM_NEG_THIRD = 2'h0;
   localparam logic [1:0] SYM_POS_THIRD = 2'h2;
   localparam logic [1:0] SYM_POS_FULL = 2'h3;
   // deviation, units of fxosc / 2^DEV_FRAC_BITS
   localparam int DEV_FRAC_BITS = 17;
   localparam logic [10:0] DEV_MANT_BASE = 11'h008;
   localparam logic [10:0] DEV_ZERO = 11'h000;
   // signal strength, half-dB steps
   localparam logic [19:0] RSSI_DIV = 20'h00008;
   localparam logic [19:0] RSSI_CNT_ONE = 20'h00001;
   localparam logic [7:0] CS_HYST = 8'h02;
   localparam logic [7:0] REL_6DB = 8'h0C;
   localparam logic [7:0] REL_10DB = 8'h14;
   localparam logic [7:0] REL_14DB = 8'h1C;
   // byte assembly
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] BITS_ONE = 4'h1;
   localparam logic [3:0] BITS_TWO = 4'h2;
   localparam logic [7:0] LEN_ONE = 8'h01;
   localparam int CRC_OK_BIT = 7;
   // packet status and byte count bit positions
   localparam int PST_PIN0 = 0;
   localparam int PST_PIN2 = 2;
   localparam int PST_SYNC = 3;
   localparam int PST_CS = 6;
   localparam int PST_CRC = 7;
   localparam int OVF_BIT = 7;
   typedef enum logic [2:0] {
      RXQ_IDLE, RXQ_SEARCH, RXQ_PAYLOAD, RXQ_APP1, RXQ_APP2
   } rxq_state_t;
endpackage : rxq_pkg

// *** rxq_top.sv ***
`timescale 1ns/1ps
module rxq_top (
   // clock and control
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic rx_on,
   // link pins, asynchronous
   input wire logic link_clk,
   input wire logic [1:0] link_level,
   // configuration
   input wire logic [5:0] pin_function_code_two,
   input wire logic [5:0] pin_function_code_zero,
   input wire logic [2:0] sync_mode,
   input wire logic [2:0] mod_format,
   input wire logic manchester_en,
   input wire logic [15:0] sync_word,
   input wire logic [2:0] dev_mantissa,
   input wire logic [2:0] dev_exponent,
   input wire logic [1:0] filter_length,
   input wire logic [7:0] chan_half_cycles,
   input wire logic [7:0] cs_abs_thr,
   input wire logic [1:0] cs_rel_thr,
   input wire logic [6:0] fifo_thr,
   input wire logic [7:0] pkt_len,
   input wire logic enable_a,
   // strength estimator and crc checker
   input wire logic [7:0] rssi_in,
   input wire logic crc_ok_in,
   // host fifo read
   input wire logic fifo_rd,
   // outputs
   output logic [7:0] rd_data_r,
   output logic general_output_two_r,
   output logic general_output_zero_r,
   output logic [7:0] packet_status_reg_r,
   output logic [7:0] receive_byte_count_reg_r,
   output logic [7:0] status_byte_r,
   output logic [7:0] rssi_r,
   output logic carrier_sense_r,
   output logic [10:0] expected_dev_r,
   output logic [1:0] demod_sym_r
);
   logic [7:0] mem [rxq_pkg::FIFO_DEPTH];
   logic ck_s1_r, ck_s2_r, ck_s3_r;
   logic [1:0] lv_s1_r, lv_s2_r;
   rxq_pkg::rxq_state_t st_r, st_nxt;
   logic [31:0] sync_sh_r, sync_sh_nxt;
   logic [7:0] byte_sh_r, byte_sh_nxt;
   logic [3:0] bit_cnt_r, bit_cnt_nxt;
   logic [7:0] len_cnt_r, len_cnt_nxt;
   logic man_ph_r, man_ph_nxt;
   logic [5:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [6:0] cnt_r, cnt_nxt;
   logic ovf_r, ovf_nxt, in_pkt_r, in_pkt_nxt, eop_r, eop_nxt;
   logic rx_d_r, rx_d_nxt;
   logic [19:0] rs_cnt_r, rs_cnt_nxt;
   logic [7:0] rssi_nxt, pkt_rssi_r, pkt_rssi_nxt, prev_r, prev_nxt;
   logic abs_r, abs_nxt, rel_r, rel_nxt, cs_nxt, frz_r, frz_nxt;
   logic [7:0] rd_nxt, pst_nxt, rbc_nxt, stb_nxt;
   logic [1:0] pin_nxt, sym_nxt;
   logic [5:0] pin_code [2];
   logic [10:0] dev_nxt;
   logic wr_en;
   logic [7:0] wr_data;

   function automatic logic [5:0] errs(input logic [31:0] x);
      logic [5:0] n;
      n = rxq_pkg::ERR_NONE;
      for (int i = 0; i < 32; i++) begin
         n = n + 6'(x[i]);
      end
      return n;
   endfunction : errs

   function automatic logic [1:0] map4(input logic [1:0] lv);
      case (lv)
         rxq_pkg::LVL_NEG_FULL: map4 = rxq_pkg::SYM_NEG_FULL;
         rxq_pkg::LVL_NEG_THIRD: map4 = rxq_pkg::SYM_NEG_THIRD;
         rxq_pkg::LVL_POS_THIRD: map4 = rxq_pkg::SYM_POS_THIRD;
         default: map4 = rxq_pkg::SYM_POS_FULL;
      endcase
   endfunction : map4

   // link pins pass two flops; third flop only feeds the edge detect
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ck_s1_r <= 1'b0;
         ck_s2_r <= 1'b0;
         ck_s3_r <= 1'b0;
         lv_s1_r <= 2'h0;
         lv_s2_r <= 2'h0;
      end else if (clk_en) begin
         ck_s1_r <= link_clk;
         ck_s2_r <= ck_s1_r;
         ck_s3_r <= ck_s2_r;
         lv_s1_r <= link_level;
         lv_s2_r <= lv_s1_r;
      end
   end

   assign pin_code[0] = pin_function_code_zero;
   assign pin_code[1] = pin_function_code_two;

   always_comb begin
      logic sym_evt, fsk4, lvl2, byte_done, srch_ok, rs_stb;
      logic [1:0] md;
      logic [5:0] e16, e32;
      logic [31:0] sh;
      logic [7:0] step, rthr;
      logic [19:0] rs_per;
      logic [6:0] cnt_w;
      sym_evt = ck_s2_r & ~ck_s3_r;
      fsk4 = (mod_format == rxq_pkg::MOD_4FSK);
      lvl2 = lv_s2_r[1];
      md = sync_mode[1:0];
      sh = {sync_sh_r[30:0], lvl2};
      step = rssi_in - prev_r;
      st_nxt = st_r;
      sync_sh_nxt = sync_sh_r;
      byte_sh_nxt = byte_sh_r;
      bit_cnt_nxt = bit_cnt_r;
      len_cnt_nxt = len_cnt_r;
      man_ph_nxt = man_ph_r;
      in_pkt_nxt = in_pkt_r;
      eop_nxt = eop_r;
      sym_nxt = demod_sym_r;
      wr_en = 1'b0;
      wr_data = byte_sh_r;
      byte_done = 1'b0;
      rx_d_nxt = rx_on;
      // carrier sense
      rs_per = (20'(chan_half_cycles) * rxq_pkg::RSSI_DIV) << filter_length;
      rs_stb = (rs_cnt_r >= rs_per - rxq_pkg::RSSI_CNT_ONE);
      rs_cnt_nxt = (rs_stb || !rx_on) ? 20'h00000
                 : rs_cnt_r + rxq_pkg::RSSI_CNT_ONE;
      rssi_nxt = rssi_r;
      frz_nxt = frz_r;
      pkt_rssi_nxt = pkt_rssi_r;
      prev_nxt = prev_r;
      abs_nxt = abs_r;
      rel_nxt = rel_r;
      case (cs_rel_thr)
         2'h1: rthr = rxq_pkg::REL_6DB;
         2'h2: rthr = rxq_pkg::REL_10DB;
         default: rthr = rxq_pkg::REL_14DB;
      endcase
      if (rx_on && rs_stb) begin
         // frozen reading held from sync until the next receive entry; packet copy keeps moving
         if (!frz_r) begin
            rssi_nxt = rssi_in;
         end
         pkt_rssi_nxt = rssi_in;
         prev_nxt = rssi_in;
         if ($signed(rssi_in) > $signed(cs_abs_thr)) begin
            abs_nxt = 1'b1;
         end else if ($signed(rssi_in) <
                      $signed(cs_abs_thr - rxq_pkg::CS_HYST)) begin
            abs_nxt = 1'b0;
         end
         if (!step[7] && step >= rthr) begin
            rel_nxt = 1'b1;
         end else if (step[7] && (prev_r - rssi_in) >= rthr) begin
            rel_nxt = 1'b0;
         end
      end
      if (cs_rel_thr == 2'h0) begin
         rel_nxt = 1'b0;
      end
      cs_nxt = abs_nxt | rel_nxt;
      e16 = errs({16'h0000, sh[15:0] ^ sync_word});
      e32 = errs(sh ^ {sync_word, sync_word});
      case (md)
         rxq_pkg::SYNC_NONE: srch_ok = 1'b1;
         rxq_pkg::SYNC_15_16: srch_ok = (e16 <= rxq_pkg::ERR_16);
         rxq_pkg::SYNC_16_16: srch_ok = (e16 == rxq_pkg::ERR_NONE);
         default: srch_ok = (e32 <= rxq_pkg::ERR_32);
      endcase
      // qualified search only while carrier is sensed
      if (sync_mode[rxq_pkg::SYNC_CS_BIT] && !carrier_sense_r) begin
         srch_ok = 1'b0;
      end
      case (st_r)
         rxq_pkg::RXQ_IDLE: begin
            if (rx_on) begin
               st_nxt = rxq_pkg::RXQ_SEARCH;
            end
         end
         rxq_pkg::RXQ_SEARCH: begin
            if (sym_evt) begin
               // sync always taken as two-level, even for four-level
               sync_sh_nxt = sh;
               sym_nxt = {1'b0, lvl2};
            end
            if (srch_ok && (md == rxq_pkg::SYNC_NONE || sym_evt)) begin
               st_nxt = rxq_pkg::RXQ_PAYLOAD;
               in_pkt_nxt = 1'b1;
               frz_nxt = (md != rxq_pkg::SYNC_NONE);
               eop_nxt = 1'b0;
               bit_cnt_nxt = 4'h0;
               len_cnt_nxt = 8'h00;
               man_ph_nxt = 1'b0;
               sync_sh_nxt = 32'h00000000;
            end
         end
         rxq_pkg::RXQ_PAYLOAD: begin
            if (sym_evt) begin
               if (fsk4) begin
                  sym_nxt = map4(lv_s2_r);
                  byte_sh_nxt = {byte_sh_r[5:0], sym_nxt};
                  bit_cnt_nxt = bit_cnt_r + rxq_pkg::BITS_TWO;
               end else if (manchester_en) begin
                  // decoded bit is the first half of each chip pair
                  man_ph_nxt = ~man_ph_r;
                  if (!man_ph_r) begin
                     sym_nxt = {1'b0, lvl2};
                     byte_sh_nxt = {byte_sh_r[6:0], lvl2};
                     bit_cnt_nxt = bit_cnt_r + rxq_pkg::BITS_ONE;
                  end
               end else begin
                  sym_nxt = {1'b0, lvl2};
                  byte_sh_nxt = {byte_sh_r[6:0], lvl2};
                  bit_cnt_nxt = bit_cnt_r + rxq_pkg::BITS_ONE;
               end
               byte_done = (bit_cnt_nxt == rxq_pkg::BYTE_BITS);
            end
            if (byte_done) begin
               wr_en = 1'b1;
               wr_data = byte_sh_nxt;
               bit_cnt_nxt = 4'h0;
               len_cnt_nxt = len_cnt_r + rxq_pkg::LEN_ONE;
               if (len_cnt_nxt == pkt_len) begin
                  st_nxt = enable_a ? rxq_pkg::RXQ_APP1
                         : rxq_pkg::RXQ_SEARCH;
                  in_pkt_nxt = enable_a;
                  eop_nxt = ~enable_a;
               end
            end
         end
         rxq_pkg::RXQ_APP1: begin
            wr_en = 1'b1;
            wr_data = pkt_rssi_r;
            st_nxt = rxq_pkg::RXQ_APP2;
         end
         rxq_pkg::RXQ_APP2: begin
            wr_en = 1'b1;
            wr_data = 8'h00;
            wr_data[rxq_pkg::CRC_OK_BIT] = crc_ok_in;
            st_nxt = rxq_pkg::RXQ_SEARCH;
            in_pkt_nxt = 1'b0;
            eop_nxt = 1'b1;
         end
         default: st_nxt = rxq_pkg::RXQ_IDLE;
      endcase
      if (!rx_on) begin
         st_nxt = rxq_pkg::RXQ_IDLE;
         in_pkt_nxt = 1'b0;
      end
      // fresh receive entry releases the held strength reading
      if (rx_on && !rx_d_r) begin
         in_pkt_nxt = 1'b0;
         frz_nxt = 1'b0;
         eop_nxt = 1'b0;
      end
      // fifo: a byte arriving when full is dropped and flagged
      ovf_nxt = ovf_r | (wr_en && cnt_r == rxq_pkg::FIFO_FULL);
      if (rx_on && !rx_d_r) begin
         ovf_nxt = 1'b0;
      end
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      rd_nxt = rd_data_r;
      cnt_w = cnt_r;
      if (wr_en && cnt_r != rxq_pkg::FIFO_FULL) begin
         wp_nxt = wp_r + 6'h01;
         cnt_w = cnt_w + rxq_pkg::CNT_ONE;
      end
      if (fifo_rd && cnt_r != 7'h00) begin
         rd_nxt = mem[rp_r];
         rp_nxt = rp_r + 6'h01;
         cnt_w = cnt_w - rxq_pkg::CNT_ONE;
      end
      cnt_nxt = cnt_w;
      if (cnt_nxt == 7'h00) begin
         eop_nxt = 1'b0;
      end
      // general output pins, one per code slot
      for (int p = 0; p < 2; p++) begin
         case (pin_code[p])
            rxq_pkg::PIN_FIFO_THR: pin_nxt[p] = (cnt_nxt >= fifo_thr);
            rxq_pkg::PIN_FIFO_EOP: pin_nxt[p] =
               (cnt_nxt >= fifo_thr) | eop_nxt;
            rxq_pkg::PIN_SYNC_PKT: pin_nxt[p] = in_pkt_nxt;
            rxq_pkg::PIN_CS: pin_nxt[p] = cs_nxt;
            default: pin_nxt[p] = 1'b0;
         endcase
      end
      pst_nxt = 8'h00;
      pst_nxt[rxq_pkg::PST_PIN0] = pin_nxt[0];
      pst_nxt[rxq_pkg::PST_PIN2] = pin_nxt[1];
      pst_nxt[rxq_pkg::PST_SYNC] = in_pkt_nxt;
      pst_nxt[rxq_pkg::PST_CS] = cs_nxt;
      pst_nxt[rxq_pkg::PST_CRC] = crc_ok_in;
      rbc_nxt = {1'b0, cnt_nxt};
      rbc_nxt[rxq_pkg::OVF_BIT] = ovf_nxt;
      // status byte count saturates at fifteen
      stb_nxt = {1'b0, 3'(st_nxt),
         (cnt_nxt > 7'(rxq_pkg::STB_CNT_MAX)) ? rxq_pkg::STB_CNT_MAX
                                              : cnt_nxt[3:0]};
      // on-off keying: deviation not applied to the demodulator
      if (mod_format == rxq_pkg::MOD_OOK) begin
         dev_nxt = rxq_pkg::DEV_ZERO;
      end else begin
         dev_nxt = (rxq_pkg::DEV_MANT_BASE + 11'(dev_mantissa))
                   << dev_exponent;
      end
   end

   always_ff @(posedge core_clk) begin
      if (clk_en && wr_en && cnt_r != rxq_pkg::FIFO_FULL) begin
         mem[wp_r] <= wr_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_r <= rxq_pkg::RXQ_IDLE;
         sync_sh_r <= 32'h00000000;
         byte_sh_r <= 8'h00;
         bit_cnt_r <= 4'h0;
         len_cnt_r <= 8'h00;
         man_ph_r <= 1'b0;
         wp_r <= 6'h00;
         rp_r <= 6'h00;
         cnt_r <= 7'h00;
         ovf_r <= 1'b0;
         in_pkt_r <= 1'b0;
         eop_r <= 1'b0;
         rx_d_r <= 1'b0;
         rs_cnt_r <= 20'h00000;
         rssi_r <= 8'h80;
         pkt_rssi_r <= 8'h80;
         prev_r <= 8'h80;
         abs_r <= 1'b0;
         rel_r <= 1'b0;
         frz_r <= 1'b0;
         carrier_sense_r <= 1'b0;
         rd_data_r <= 8'h00;
         general_output_zero_r <= 1'b0;
         general_output_two_r <= 1'b0;
         packet_status_reg_r <= 8'h00;
         receive_byte_count_reg_r <= 8'h00;
         status_byte_r <= 8'h00;
         expected_dev_r <= 11'h000;
         demod_sym_r <= 2'h0;
      end else if (clk_en) begin
         st_r <= st_nxt;
         sync_sh_r <= sync_sh_nxt;
         byte_sh_r <= byte_sh_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         len_cnt_r <= len_cnt_nxt;
         man_ph_r <= man_ph_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         ovf_r <= ovf_nxt;
         in_pkt_r <= in_pkt_nxt;
         eop_r <= eop_nxt;
         rx_d_r <= rx_d_nxt;
         rs_cnt_r <= rs_cnt_nxt;
         rssi_r <= rssi_nxt;
         pkt_rssi_r <= pkt_rssi_nxt;
         prev_r <= prev_nxt;
         abs_r <= abs_nxt;
         rel_r <= rel_nxt;
         frz_r <= frz_nxt;
         carrier_sense_r <= cs_nxt;
         rd_data_r <= rd_nxt;
         general_output_zero_r <= pin_nxt[0];
         general_output_two_r <= pin_nxt[1];
         packet_status_reg_r <= pst_nxt;
         receive_byte_count_reg_r <= rbc_nxt;
         status_byte_r <= stb_nxt;
         expected_dev_r <= dev_nxt;
         demod_sym_r <= sym_nxt;
      end
   end
endmodule : rxq_top

// *** rxq_dummy_unused.sv ***
`timescale 1ns/1ps

// *** rxq_link_src.sv ***
`timescale 1ns/1ps
module rxq_link_src (
   // link pins
   output logic link_clk,
   output logic [1:0] link_level
);
   initial begin
      link_clk = 1'b0;
      link_level = 2'h0;
   end
   // one symbol per 80 ns, level set while the clock is low
   task automatic send_sym(input logic [1:0] lvl);
      link_level = lvl;
      #40;
      link_clk = 1'b1;
      #40;
      link_clk = 1'b0;
   endtask : send_sym
   // clock stands still; line no longer shows the last level
   task automatic idle();
      link_level = ~link_level;
   endtask : idle
   // sync and payload always go out as two-level symbols, msb first
   task automatic send_bits(input logic [15:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         send_sym(v[i] ? 2'h3 : 2'h0);
      end
      idle();
   endtask : send_bits
endmodule : rxq_link_src

// *** rxq_properties.sv ***
`timescale 1ns/1ps
module rxq_properties (
   // clock and control
   input wire logic core_clk,
   input wire logic rst,
   input wire logic rx_on,
   // configuration and strength input
   input wire logic [2:0] sync_mode,
   input wire logic [2:0] mod_format,
   input wire logic [2:0] dev_mantissa,
   input wire logic [2:0] dev_exponent,
   input wire logic [5:0] pin_function_code_zero,
   input wire logic [1:0] filter_length,
   input wire logic [7:0] chan_half_cycles,
   input wire logic [7:0] cs_abs_thr,
   input wire logic [1:0] cs_rel_thr,
   input wire logic [6:0] fifo_thr,
   input wire logic [7:0] rssi_in,
   // observed outputs
   input wire logic general_output_two_r,
   input wire logic general_output_zero_r,
   input wire logic [7:0] packet_status_reg_r,
   input wire logic [7:0] receive_byte_count_reg_r,
   input wire logic [7:0] status_byte_r,
   input wire logic [7:0] rssi_r,
   input wire logic carrier_sense_r,
   input wire logic [10:0] expected_dev_r
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   logic [5:0] hi_cnt_r, hi_cnt_nxt, lo_cnt_r, lo_cnt_nxt;
   logic fast_cs, thr_hit;
   logic [3:0] cnt_low;
   // judged at the 16-cycle sample period only
   assign fast_cs = rx_on && cs_rel_thr == 2'h0 && filter_length == 2'h0
      && chan_half_cycles == 8'h02;
   assign thr_hit = receive_byte_count_reg_r[6:0] >= fifo_thr;
   assign cnt_low = (receive_byte_count_reg_r[6:0] > 7'h0F) ? 4'hF
      : receive_byte_count_reg_r[3:0];
   always_comb begin
      hi_cnt_nxt = 6'h00;
      lo_cnt_nxt = 6'h00;
      if (fast_cs && $signed(rssi_in) > $signed(cs_abs_thr) + 4) begin
         hi_cnt_nxt = hi_cnt_r + {5'h00, hi_cnt_r != 6'h3F};
      end
      if (fast_cs && $signed(rssi_in) < $signed(cs_abs_thr) - 4) begin
         lo_cnt_nxt = lo_cnt_r + {5'h00, lo_cnt_r != 6'h3F};
      end
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         hi_cnt_r <= 6'h00;
         lo_cnt_r <= 6'h00;
      end else begin
         hi_cnt_r <= hi_cnt_nxt;
         lo_cnt_r <= lo_cnt_nxt;
      end
   end
   sequence dev_cfg_held;
      $stable(mod_format) && $stable(dev_mantissa) && $stable(dev_exponent);
   endsequence
   sequence in_packet;
      rx_on && sync_mode[1:0] != 2'h0 && packet_status_reg_r[3];
   endsequence
   dev_ook_a: assert property (dev_cfg_held [*3] ##0
      mod_format == rxq_pkg::MOD_OOK |-> expected_dev_r == 11'h000)
      else $error("deviation not zero in on-off keying");
   dev_value_a: assert property (dev_cfg_held [*3] ##0
      mod_format != rxq_pkg::MOD_OOK |-> expected_dev_r ==
      (rxq_pkg::DEV_MANT_BASE + {8'h00, dev_mantissa}) << dev_exponent)
      else $error("deviation value wrong");
   pin_status_a: assert property (packet_status_reg_r[2] ==
      general_output_two_r || packet_status_reg_r[2] ==
      $past(general_output_two_r)) else $error("status pin bit wrong");
   fifo_pin_a: assert property (pin_function_code_zero ==
      rxq_pkg::PIN_FIFO_THR && $stable(pin_function_code_zero) &&
      $stable(fifo_thr) |-> general_output_zero_r == thr_hit ||
      general_output_zero_r == $past(thr_hit)) else $error("fill pin wrong");
   cs_pin_a: assert property (pin_function_code_zero ==
      rxq_pkg::PIN_CS && $stable(pin_function_code_zero) |->
      general_output_zero_r == carrier_sense_r || general_output_zero_r ==
      $past(carrier_sense_r)) else $error("carrier pin wrong");
   status_count_a: assert property (status_byte_r[3:0] == cnt_low ||
      status_byte_r[3:0] == $past(cnt_low)) else $error("status count wrong");
   rssi_hold_a: assert property (in_packet [*3] |-> $stable(rssi_r))
      else $error("strength moved after sync");
   cs_rise_a: assert property (hi_cnt_r >= 6'h28 |-> carrier_sense_r)
      else $error("carrier sense missing above threshold");
   cs_fall_a: assert property (lo_cnt_r >= 6'h28 |-> !carrier_sense_r)
      else $error("carrier sense stuck below threshold");
endmodule : rxq_properties

// *** rxq_top_tb.sv ***
`timescale 1ns/1ps
module rxq_top_tb;
   typedef struct packed {
      logic [2:0] fmt;
      logic [2:0] mant;
      logic [2:0] ex;
      logic [1:0] lvl;
      logic [10:0] dev;
      logic [1:0] sym;
      logic sym_chk;
   } rxq_row_t;
   rxq_row_t rows [8] = '{'{3'h0, 3'h0, 3'h0, 2'h0, 11'h008, 2'h0, 1'b1},
      '{3'h0, 3'h7, 3'h7, 2'h3, 11'h780, 2'h1, 1'b1},
      '{3'h1, 3'h3, 3'h2, 2'h2, 11'h02C, 2'h1, 1'b1},
      '{3'h4, 3'h1, 3'h5, 2'h0, 11'h120, 2'h1, 1'b1},
      '{3'h4, 3'h2, 3'h1, 2'h1, 11'h014, 2'h0, 1'b1},
      '{3'h4, 3'h4, 3'h3, 2'h2, 11'h060, 2'h2, 1'b1},
      '{3'h4, 3'h6, 3'h0, 2'h3, 11'h00E, 2'h3, 1'b1},
      '{3'h3, 3'h5, 3'h5, 2'h3, 11'h000, 2'h0, 1'b0}};
   logic [2:0] modes [3] = '{3'h1, 3'h3, 3'h5};
   logic [1:0] hits [3] = '{2'b11, 2'b01, 2'b00};
   logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, rx_on = 1'b0;
   // decoding stays off, never paired with four-level keying
   logic manchester_en = 1'b0, enable_a = 1'b1, crc_ok_in = 1'b1;
   logic fifo_rd = 1'b0, link_clk;
   logic [1:0] link_level, filter_length = 2'h0, cs_rel_thr = 2'h0;
   logic [2:0] sync_mode = 3'h0, mod_format = 3'h0;
   logic [2:0] dev_mantissa = 3'h0, dev_exponent = 3'h0;
   logic [5:0] pin_function_code_two = rxq_pkg::PIN_SYNC_PKT;
   logic [5:0] pin_function_code_zero = rxq_pkg::PIN_FIFO_THR;
   logic [6:0] fifo_thr = 7'h03;
   logic [7:0] chan_half_cycles = 8'h02, cs_abs_thr = 8'h10;
   logic [7:0] pkt_len = 8'hFF, rssi_in = 8'hD0;
   logic [15:0] sync_word = 16'hD391;
   logic [7:0] rd_data_r, packet_status_reg_r, receive_byte_count_reg_r;
   logic [7:0] status_byte_r, rssi_r;
   logic general_output_two_r, general_output_zero_r, carrier_sense_r;
   logic [10:0] expected_dev_r;
   logic [1:0] demod_sym_r;
   int err_total = 0, cmp_count = 0;
   always #5 core_clk = ~core_clk;
   rxq_link_src src (.link_clk(link_clk), .link_level(link_level));
   rxq_top uut (
      .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .rx_on(rx_on),
      .link_clk(link_clk), .link_level(link_level),
      .pin_function_code_two(pin_function_code_two),
      .pin_function_code_zero(pin_function_code_zero),
      .sync_mode(sync_mode), .mod_format(mod_format),
      .manchester_en(manchester_en), .sync_word(sync_word),
      .dev_mantissa(dev_mantissa), .dev_exponent(dev_exponent),
      .filter_length(filter_length), .chan_half_cycles(chan_half_cycles),
      .cs_abs_thr(cs_abs_thr), .cs_rel_thr(cs_rel_thr), .fifo_thr(fifo_thr),
      .pkt_len(pkt_len), .enable_a(enable_a), .rssi_in(rssi_in),
      .crc_ok_in(crc_ok_in), .fifo_rd(fifo_rd), .rd_data_r(rd_data_r),
      .general_output_two_r(general_output_two_r),
      .general_output_zero_r(general_output_zero_r),
      .packet_status_reg_r(packet_status_reg_r),
      .receive_byte_count_reg_r(receive_byte_count_reg_r),
      .status_byte_r(status_byte_r), .rssi_r(rssi_r),
      .carrier_sense_r(carrier_sense_r), .expected_dev_r(expected_dev_r),
      .demod_sym_r(demod_sym_r)
   );
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   task automatic chk_val(input logic [10:0] got, input logic [10:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_bit(input logic got, input logic exp);
      chk_val({10'h000, got}, {10'h000, exp});
   endtask : chk_bit
   task automatic do_reset();
      rst = 1'b1;
      rx_on = 1'b0;
      tick(8);
      rst = 1'b0;
      tick(2);
      rx_on = 1'b1;
      tick(40);
   endtask : do_reset
   task automatic wait_count(input logic [6:0] n);
      int i;
      for (i = 0; i < 300 && receive_byte_count_reg_r[6:0] !== n; i++) begin
         @(negedge core_clk);
      end
      if (i == 300) begin
         err_total++;
         $display("wrong value at %0t: fifo count never reached", $time);
         conclude();
      end
   endtask : wait_count
   // one-cycle pop; data ready next edge
   task automatic pop(input logic [7:0] exp);
      fifo_rd = 1'b1;
      @(negedge core_clk);
      fifo_rd = 1'b0;
      @(negedge core_clk);
      chk_val({3'h0, rd_data_r}, {3'h0, exp});
   endtask : pop
   initial begin
      tick(8);
      rst = 1'b0;
      tick(2);
      chk_val({3'h0, receive_byte_count_reg_r}, 11'h000);
      rx_on = 1'b1;
      tick(4);
      foreach (rows[i]) begin
         mod_format = rows[i].fmt;
         dev_mantissa = rows[i].mant;
         dev_exponent = rows[i].ex;
         src.send_sym(rows[i].lvl);
         src.idle();
         tick(8);
         chk_val(expected_dev_r, rows[i].dev);
         if (rows[i].sym_chk) begin
            chk_val({9'h000, demod_sym_r}, {9'h000, rows[i].sym});
         end
      end
      $display("test table done");
      mod_format = 3'h0;
      foreach (modes[i]) begin
         sync_mode = modes[i];
         do_reset();
         src.send_bits(16'hD390, 16);
         tick(8);
         chk_bit(packet_status_reg_r[3], hits[i][1]);
         src.send_bits(16'hD391, 16);
         tick(8);
         chk_bit(packet_status_reg_r[3], hits[i][0]);
      end
      $display("test qualifier modes done");
      sync_mode = 3'h2;
      pkt_len = 8'h01;
      crc_ok_in = 1'b0;
      do_reset();
      src.send_bits(16'hD390, 16);
      tick(8);
      chk_val({3'h0, receive_byte_count_reg_r}, 11'h000);
      chk_bit(general_output_two_r, 1'b0);
      src.send_bits(16'hD391, 16);
      tick(8);
      chk_bit(general_output_two_r, 1'b1);
      chk_bit(packet_status_reg_r[2], 1'b1);
      src.send_bits(16'h00A5, 8);
      wait_count(7'h03);
      tick(4);
      chk_bit(general_output_two_r, 1'b0);
      chk_bit(general_output_zero_r, 1'b1);
      chk_bit(packet_status_reg_r[0], 1'b1);
      chk_val({7'h00, status_byte_r[3:0]}, 11'h003);
      chk_val({3'h0, receive_byte_count_reg_r}, 11'h003);
      pin_function_code_zero = rxq_pkg::PIN_FIFO_EOP;
      fifo_thr = 7'h7F;
      tick(2);
      chk_bit(general_output_zero_r, 1'b1);
      rssi_in = 8'h20;
      tick(40);
      chk_val({3'h0, rssi_r}, 11'h0D0);
      pop(8'hA5);
      pop(8'hD0);
      pop(8'h00);
      tick(2);
      chk_val({3'h0, receive_byte_count_reg_r}, 11'h000);
      $display("test packet done");
      sync_mode = 3'h4;
      pin_function_code_zero = rxq_pkg::PIN_CS;
      rssi_in = 8'hF0;
      do_reset();
      tick(20);
      chk_bit(carrier_sense_r, 1'b0);
      chk_bit(packet_status_reg_r[3], 1'b0);
      rssi_in = 8'h30;
      tick(60);
      chk_bit(carrier_sense_r, 1'b1);
      chk_bit(general_output_zero_r, 1'b1);
      chk_bit(packet_status_reg_r[6], 1'b1);
      chk_bit(packet_status_reg_r[3], 1'b1);
      rssi_in = 8'hF0;
      tick(60);
      chk_bit(carrier_sense_r, 1'b0);
      cs_rel_thr = 2'h1;
      rssi_in = 8'hC0;
      tick(60);
      chk_bit(carrier_sense_r, 1'b0);
      rssi_in = 8'hD0;
      tick(60);
      chk_bit(carrier_sense_r, 1'b1);
      rssi_in = 8'hC0;
      tick(60);
      chk_bit(carrier_sense_r, 1'b0);
      $display("test carrier sense done");
      conclude();
   end
endmodule : rxq_top_tb
bind rxq_top rxq_properties chk (
   .core_clk(core_clk), .rst(rst), .rx_on(rx_on), .sync_mode(sync_mode),
   .mod_format(mod_format), .dev_mantissa(dev_mantissa),
   .dev_exponent(dev_exponent), .pin_function_code_zero(pin_function_code_zero),
   .filter_length(filter_length), .chan_half_cycles(chan_half_cycles),
   .cs_abs_thr(cs_abs_thr), .cs_rel_thr(cs_rel_thr), .fifo_thr(fifo_thr),
   .rssi_in(rssi_in), .general_output_two_r(general_output_two_r),
   .general_output_zero_r(general_output_zero_r),
   .packet_status_reg_r(packet_status_reg_r),
   .receive_byte_count_reg_r(receive_byte_count_reg_r),
   .status_byte_r(status_byte_r), .rssi_r(rssi_r),
   .carrier_sense_r(carrier_sense_r), .expected_dev_r(expected_dev_r)
);
